/* File: design/acc_defs.svh */
// register map, field positions, reset values and timing counts
`ifndef ACC_DEFS_SVH
`define ACC_DEFS_SVH

// ************************************************************
// register word indices (byte address is four times the index)
// ************************************************************
`define ACC_IDX_CONTROL 4'h0
`define ACC_IDX_REFERENCE 4'h1
`define ACC_IDX_AVERAGING 4'h2
`define ACC_IDX_SAMPLING 4'h3
`define ACC_IDX_CONFIG_B 4'h4
`define ACC_IDX_STATUS 4'h6
`define ACC_IDX_RESULT 4'h8
`define ACC_IDX_GAIN 4'h9
`define ACC_IDX_OFFSET 4'hA

// ************************************************************
// field positions
// ************************************************************
`define ACC_CTL_START_BIT 0
`define ACC_CTL_ENABLE_BIT 1
`define ACC_REF_COMP_BIT 7
`define ACC_REF_SEL_LSB 0
`define ACC_AVG_SHIFT_LSB 4
`define ACC_AVG_COUNT_LSB 0
`define ACC_SAMP_LEN_LSB 0
`define ACC_CFGB_PRESC_LSB 8
`define ACC_CFGB_RES_LSB 4
`define ACC_CFGB_CORR_BIT 3
`define ACC_CFGB_CONT_BIT 2
`define ACC_STAT_SYNC_BIT 7
`define ACC_STAT_BUSY_BIT 0

// ************************************************************
// reset values and codes
// ************************************************************
`define ACC_RST_BYTE 8'h00
`define ACC_RST_GAIN 12'h800
`define ACC_RST_OFFSET 12'h000
`define ACC_COUNT_MAX 4'hA
`define ACC_RES_12 2'h0
`define ACC_RES_16 2'h1
`define ACC_RES_10 2'h2
`define ACC_RES_8 2'h3
`define ACC_MAX_12 16'h0FFF
`define ACC_MAX_10 16'h03FF
`define ACC_MAX_8 16'h00FF
`define ACC_MAX_16 16'hFFFF
`define ACC_GAIN_FRAC 11

// ************************************************************
// timing counts: correction base in half periods, bit counts in full periods of the converter clock
// ************************************************************
`define ACC_CORR_EXTRA_BASE 7'h02
`define ACC_BITS_12 7'h0C
`define ACC_BITS_10 7'h0A
`define ACC_BITS_8 7'h08

`endif

/* File: design/acc_pkg.sv */
// types shared by the conversion configuration block
package acc_pkg;

    // ************************************************************
    // sequencer states
    // ************************************************************
    typedef enum logic [2:0] {
        ACC_IDLE = 3'b000,
        ACC_SAMPLE = 3'b001,
        ACC_CONVERT = 3'b010,
        ACC_CORRECT = 3'b011,
        ACC_DONE = 3'b100
    } acc_state_t;

    // ************************************************************
    // register contents
    // ************************************************************
    typedef struct packed {
        logic comp_en;
        logic [3:0] select;
    } acc_ref_t;

    typedef struct packed {
        logic [2:0] shift;
        logic [3:0] count;
    } acc_avg_t;

    typedef struct packed {
        logic [2:0] prescaler;
        logic [1:0] resolution;
        logic corr_en;
        logic cont;
    } acc_cfgb_t;

    // converter core timing strobes
    typedef struct packed {
        logic adc_clk;
        logic sampling;
        logic converting;
    } acc_core_t;

endpackage : acc_pkg

/* File: design/acc_prescaler.sv */
// converter clock divider producing half-period enable pulses
`timescale 1ns/100ps

module acc_prescaler #(
    parameter int CNT_W = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [2:0] code_i,
    output logic tick_o
);

    // ************************************************************
    // divider
    // ************************************************************
    // elaboration refuses a counter too narrow
    if (CNT_W < 8) begin : g_cnt_w_check
        $error("acc_prescaler: CNT_W must be at least 8");
    end

    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] half_m1;

    // half period is 2 << code peripheral cycles, minus one
    assign half_m1 = CNT_W'((2 << code_i) - 1);

    // count up and pulse at the end of each half period
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q <= '0;
            tick_o <= 1'b0;
        end else if (cnt_q >= half_m1) begin
            cnt_q <= '0;
            tick_o <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 1'b1;
            tick_o <= 1'b0;
        end
    end

endmodule : acc_prescaler

/* File: design/acc_top.sv */
// conversion configuration, sequencing and result formatting
//
// The Wishbone interface to the registers was decided locally.
`timescale 1ns/100ps
`include "acc_defs.svh"

// Behaviour
// R1: reference bit 7 turns reference buffer offset compensation on or off.
// R2: four-bit reference select picks one of five references; others reserved.
// R3: averaging bits 6:4 set a power-of-two division of the accumulated sum.
// R4: sample count code n sums 2^n samples, up to 1024; codes above reserved.
// R5: software widens resolution when summing grows the result.
// R6: sampling phase lasts field plus one half converter clock periods.
// R7: prescaler bits 10:8 divide peripheral clock by 4 up to 512.
// R8: resolution bits 5:4 give 12, 16, 10 or 8 bit results.
// R9: correction bit 3 applies gain and offset correction; clear applies none.
// R10: active correction adds cycles depending on the offset correction value.
// R11: free-run bit 2 restarts conversions; clear means one per trigger.
// R12: enable-protected registers ignore writes while the converter is enabled.
// R13: synchronized writes set sync pending until applied in converter timing.
// R14: division is a right shift of the sum after all samples are added.
module acc_top (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_stb_i,
    input wire logic wb_cyc_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic trigger_i,
    input wire logic [11:0] core_result_i,
    output acc_pkg::acc_core_t core_o,
    output logic [3:0] ref_select_o,
    output logic ref_buffer_comp_en_o,
    output logic [15:0] result_o,
    output logic result_ready_o
);
    import acc_pkg::*;

    // ************************************************************
    // registers
    // ************************************************************
    logic enable_q;
    logic start_q;
    acc_ref_t reference_q;
    acc_avg_t averaging_q;
    logic [5:0] sample_phase_length_q;
    acc_cfgb_t cfgb_shadow_q;
    acc_cfgb_t cfgb_q;
    logic sync_pending_q;
    logic [11:0] gain_correction_value_q;
    logic [11:0] offset_correction_value_q;
    logic [15:0] result_q;
    logic busy_q;

    // ************************************************************
    // bus decode
    // ************************************************************
    logic req;
    logic wr;
    logic mapped;
    logic [3:0] idx;
    logic tick;
    logic start_taken;
    acc_state_t state_q;
    acc_state_t state_d;

    assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr = req & wb_we_i;
    assign mapped = (wb_adr_i[7:6] == 2'h0) & (wb_adr_i[1:0] == 2'h0);
    assign idx = wb_adr_i[5:2];

    // one-cycle ack for every access, mapped or not
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= req;
        end
    end

    // read data captured with the ack; unmapped reads return zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h00000000;
        end else if (req & ~wb_we_i) begin
            wb_dat_o <= 32'h00000000;
            if (mapped) begin
                unique case (idx)
                    `ACC_IDX_CONTROL: begin
                        wb_dat_o[`ACC_CTL_ENABLE_BIT] <= enable_q;
                        wb_dat_o[`ACC_CTL_START_BIT] <= start_q;
                    end
                    `ACC_IDX_REFERENCE: begin
                        wb_dat_o[`ACC_REF_COMP_BIT] <= reference_q.comp_en;
                        wb_dat_o[`ACC_REF_SEL_LSB +: 4] <= reference_q.select;
                    end
                    `ACC_IDX_AVERAGING: begin
                        wb_dat_o[`ACC_AVG_SHIFT_LSB +: 3] <= averaging_q.shift;
                        wb_dat_o[`ACC_AVG_COUNT_LSB +: 4] <= averaging_q.count;
                    end
                    `ACC_IDX_SAMPLING: begin
                        wb_dat_o[`ACC_SAMP_LEN_LSB +: 6] <=
                            sample_phase_length_q;
                    end
                    `ACC_IDX_CONFIG_B: begin
                        wb_dat_o[`ACC_CFGB_PRESC_LSB +: 3] <=
                            cfgb_shadow_q.prescaler;
                        wb_dat_o[`ACC_CFGB_RES_LSB +: 2] <=
                            cfgb_shadow_q.resolution;
                        wb_dat_o[`ACC_CFGB_CORR_BIT] <= cfgb_shadow_q.corr_en;
                        wb_dat_o[`ACC_CFGB_CONT_BIT] <= cfgb_shadow_q.cont;
                    end
                    `ACC_IDX_STATUS: begin
                        wb_dat_o[`ACC_STAT_SYNC_BIT] <= sync_pending_q;
                        wb_dat_o[`ACC_STAT_BUSY_BIT] <= busy_q;
                    end
                    `ACC_IDX_RESULT: wb_dat_o[15:0] <= result_q;
                    `ACC_IDX_GAIN: wb_dat_o[11:0] <= gain_correction_value_q;
                    `ACC_IDX_OFFSET: begin
                        wb_dat_o[11:0] <= offset_correction_value_q;
                    end
                    default: wb_dat_o <= 32'h00000000;
                endcase
            end
        end
    end

    // ************************************************************
    // configuration writes
    // ************************************************************
    // enable bit and start request; a new trigger beats its own clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            enable_q <= 1'b0;
            start_q <= 1'b0;
        end else begin
            if (wr & mapped & (idx == `ACC_IDX_CONTROL) & wb_sel_i[0]) begin
                enable_q <= wb_dat_i[`ACC_CTL_ENABLE_BIT];
            end
            start_q <= (start_q & ~start_taken) | trigger_i |
                (wr & mapped & (idx == `ACC_IDX_CONTROL) & wb_sel_i[0] &
                 wb_dat_i[`ACC_CTL_START_BIT]);
        end
    end

    // reference, averaging and sampling settings
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            reference_q <= acc_ref_t'(`ACC_RST_BYTE);
            averaging_q <= acc_avg_t'(`ACC_RST_BYTE);
            sample_phase_length_q <= 6'(`ACC_RST_BYTE);
        end else if (wr & mapped & wb_sel_i[0]) begin
            // R1: compensation enable
            if (idx == `ACC_IDX_REFERENCE) begin
                reference_q.comp_en <= wb_dat_i[`ACC_REF_COMP_BIT];
                // R2: reference select
                reference_q.select <= wb_dat_i[`ACC_REF_SEL_LSB +: 4];
            end
            // R3: division shift field
            if (idx == `ACC_IDX_AVERAGING) begin
                averaging_q.shift <= wb_dat_i[`ACC_AVG_SHIFT_LSB +: 3];
                averaging_q.count <= wb_dat_i[`ACC_AVG_COUNT_LSB +: 4];
            end
            if (idx == `ACC_IDX_SAMPLING) begin
                sample_phase_length_q <= wb_dat_i[`ACC_SAMP_LEN_LSB +: 6];
            end
        end
    end

    // correction values, two byte lanes each
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            gain_correction_value_q <= `ACC_RST_GAIN;
            offset_correction_value_q <= `ACC_RST_OFFSET;
        end else if (wr & mapped) begin
            if (idx == `ACC_IDX_GAIN) begin
                if (wb_sel_i[0]) gain_correction_value_q[7:0] <= wb_dat_i[7:0];
                if (wb_sel_i[1]) gain_correction_value_q[11:8] <=
                    wb_dat_i[11:8];
            end
            if (idx == `ACC_IDX_OFFSET) begin
                if (wb_sel_i[0]) begin
                    offset_correction_value_q[7:0] <= wb_dat_i[7:0];
                end
                if (wb_sel_i[1]) begin
                    offset_correction_value_q[11:8] <= wb_dat_i[11:8];
                end
            end
        end
    end

    // config b shadow, applied on the next converter half period
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfgb_shadow_q <= acc_cfgb_t'(7'h00);
            cfgb_q <= acc_cfgb_t'(7'h00);
            sync_pending_q <= 1'b0;
        end else begin
            if (tick) begin
                cfgb_q <= cfgb_shadow_q;
            end
            // R12: refuse while enabled
            if (wr & mapped & (idx == `ACC_IDX_CONFIG_B) & ~enable_q) begin
                if (wb_sel_i[1]) begin
                    cfgb_shadow_q.prescaler <=
                        wb_dat_i[`ACC_CFGB_PRESC_LSB +: 3];
                end
                if (wb_sel_i[0]) begin
                    cfgb_shadow_q.resolution <=
                        wb_dat_i[`ACC_CFGB_RES_LSB +: 2];
                    cfgb_shadow_q.corr_en <= wb_dat_i[`ACC_CFGB_CORR_BIT];
                    cfgb_shadow_q.cont <= wb_dat_i[`ACC_CFGB_CONT_BIT];
                end
                // R13: set pending, set wins
                sync_pending_q <= 1'b1;
            end else if (tick) begin
                sync_pending_q <= 1'b0;
            end
        end
    end

    // ************************************************************
    // converter clock
    // ************************************************************
    // R7: divide by 4 to 512
    acc_prescaler #(
        .CNT_W(8)
    ) u_prescaler (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .code_i(cfgb_q.prescaler),
        .tick_o(tick)
    );

    // ************************************************************
    // sequencer
    // ************************************************************
    logic [6:0] phase_q;
    logic [6:0] phase_end;
    logic [10:0] samples_q;
    logic [10:0] samples_end;
    logic [3:0] count_code;
    logic [6:0] bits_len;
    logic [11:0] raw_trim;
    logic [21:0] acc_q;

    // R4: reserved count codes act as the largest
    assign count_code = (averaging_q.count > `ACC_COUNT_MAX) ?
        `ACC_COUNT_MAX : averaging_q.count;
    assign samples_end = 11'((12'h001 << count_code) - 12'h001);

    // R8: bit cycles and raw trimming per resolution
    always_comb begin
        unique case (cfgb_q.resolution)
            `ACC_RES_10: begin
                bits_len = `ACC_BITS_10;
                raw_trim = {2'h0, core_result_i[11:2]};
            end
            `ACC_RES_8: begin
                bits_len = `ACC_BITS_8;
                raw_trim = {4'h0, core_result_i[11:4]};
            end
            default: begin
                bits_len = `ACC_BITS_12;
                raw_trim = core_result_i;
            end
        endcase
    end

    // length of the current phase in half periods, minus one
    always_comb begin
        unique case (state_q)
            // R6: field plus one half periods
            ACC_SAMPLE: phase_end = {1'b0, sample_phase_length_q};
            ACC_CONVERT: phase_end = 7'({bits_len, 1'b0} - 8'h01);
            // R10: extra cycles follow the offset value
            ACC_CORRECT: phase_end = `ACC_CORR_EXTRA_BASE +
                7'(offset_correction_value_q[3:0]);
            default: phase_end = 7'h00;
        endcase
    end

    assign start_taken = (state_q == ACC_IDLE) & tick & enable_q & start_q;

    // next state on each half period, or idle at once when enable is clear
    always_comb begin
        state_d = state_q;
        if (~enable_q) begin
            state_d = ACC_IDLE;
        end else if (tick) begin
            unique case (state_q)
                ACC_IDLE: if (start_q) state_d = ACC_SAMPLE;
                ACC_SAMPLE: if (phase_q == phase_end) state_d = ACC_CONVERT;
                ACC_CONVERT: begin
                    if (phase_q == phase_end) begin
                        if (samples_q != samples_end) begin
                            state_d = ACC_SAMPLE;
                        end else if (cfgb_q.corr_en) begin
                            state_d = ACC_CORRECT;
                        end else begin
                            state_d = ACC_DONE;
                        end
                    end
                end
                ACC_CORRECT: if (phase_q == phase_end) state_d = ACC_DONE;
                // R11: free run restarts at once
                ACC_DONE: state_d = cfgb_q.cont ? ACC_SAMPLE : ACC_IDLE;
                default: state_d = ACC_IDLE;
            endcase
        end
    end

    // state, phase counter and accumulation
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= ACC_IDLE;
            phase_q <= 7'h00;
            samples_q <= 11'h000;
            acc_q <= 22'h000000;
        end else begin
            state_q <= state_d;
            if (state_d != state_q) begin
                phase_q <= 7'h00;
            end else if (tick) begin
                phase_q <= phase_q + 7'h01;
            end
            if ((state_q != ACC_SAMPLE) & (state_d == ACC_SAMPLE) &
                (state_q != ACC_CONVERT)) begin
                samples_q <= 11'h000;
                acc_q <= 22'h000000;
            end else if ((state_q == ACC_CONVERT) & (state_d != state_q)) begin
                // R4: sum each sample
                acc_q <= acc_q + 22'(raw_trim);
                samples_q <= samples_q + 11'h001;
            end
        end
    end

    // ************************************************************
    // result formatting
    // ************************************************************
    logic [21:0] avg;
    logic [15:0] sat16;
    logic signed [17:0] diff;
    logic signed [30:0] prod;
    logic signed [30:0] scaled;
    logic [15:0] corrected;
    logic [15:0] res_max;
    logic [15:0] final_val;

    // R14: shift after all samples are summed
    assign avg = acc_q >> averaging_q.shift;
    assign sat16 = (|avg[21:16]) ? `ACC_MAX_16 : avg[15:0];

    // R9: gain and offset correction when enabled
    assign diff = $signed({2'h0, sat16}) -
        $signed({{6{offset_correction_value_q[11]}},
                 offset_correction_value_q});
    assign prod = diff * $signed({1'b0, gain_correction_value_q});
    assign scaled = prod >>> `ACC_GAIN_FRAC;
    always_comb begin
        if (~cfgb_q.corr_en) begin
            corrected = sat16;
        end else if (scaled < 0) begin
            corrected = 16'h0000;
        end else if (|scaled[30:16]) begin
            corrected = `ACC_MAX_16;
        end else begin
            corrected = scaled[15:0];
        end
    end

    // R8: clamp to the selected result width
    always_comb begin
        unique case (cfgb_q.resolution)
            `ACC_RES_12: res_max = `ACC_MAX_12;
            `ACC_RES_10: res_max = `ACC_MAX_10;
            `ACC_RES_8: res_max = `ACC_MAX_8;
            default: res_max = `ACC_MAX_16;
        endcase
    end
    assign final_val = (corrected > res_max) ? res_max : corrected;

    // result register, ready pulse and busy flag
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            result_q <= 16'h0000;
            result_ready_o <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            result_ready_o <= (state_q == ACC_DONE) & (state_d != ACC_DONE);
            if ((state_q == ACC_DONE) & (state_d != ACC_DONE)) begin
                result_q <= final_val;
            end
            busy_q <= (state_d != ACC_IDLE);
        end
    end

    // ************************************************************
    // outputs to the converter core, reference buffer and result port
    // ************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            core_o <= acc_core_t'(3'h0);
            ref_select_o <= 4'h0;
            ref_buffer_comp_en_o <= 1'b0;
            result_o <= 16'h0000;
        end else begin
            if (tick) begin
                core_o.adc_clk <= ~core_o.adc_clk;
            end
            core_o.sampling <= (state_d == ACC_SAMPLE);
            core_o.converting <= (state_d == ACC_CONVERT);
            // R2: reference choice to the core
            ref_select_o <= reference_q.select;
            // R1: compensation to the buffer
            ref_buffer_comp_en_o <= reference_q.comp_en;
            result_o <= result_q;
        end
    end

endmodule : acc_top

/* File: verification/acc_top_props.sv */
// concurrent checks on the ports of the conversion configuration block
`timescale 1ns/100ps
module acc_top_props (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_stb_i,
    input wire logic wb_cyc_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic trigger_i,
    input wire logic [11:0] core_result_i,
    input wire acc_pkg::acc_core_t core_o,
    input wire logic [3:0] ref_select_o,
    input wire logic ref_buffer_comp_en_o,
    input wire logic [15:0] result_o,
    input wire logic result_ready_o
);
    import acc_pkg::*;
    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic req;
    logic ref_wr;
    // request taken and reference write seen
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign ref_wr = req && wb_we_i && wb_adr_i == 8'h04 && wb_sel_i[0];
    a_ack_latency: assert property (req |=> wb_ack_o)
        else $error("bus request not acknowledged");
    a_ref_sel_copy: assert property (ref_wr |=> ##1
        ref_select_o == $past(wb_dat_i[3:0], 2)) else $error("ref select");
    a_comp_en_copy: assert property (ref_wr |=> ##1
        ref_buffer_comp_en_o == $past(wb_dat_i[7], 2)) else $error("comp");
    a_adc_clk_rate: assert property ($changed(core_o.adc_clk) |=>
        $stable(core_o.adc_clk)) else $error("converter clock too fast");
    a_sample_then_conv: assert property ($rose(core_o.converting) |->
        $past(core_o.sampling)) else $error("conversion without sampling");
    a_phase_excl: assert property (!(core_o.sampling
        && core_o.converting)) else $error("phases overlap");
    a_ready_pulse: assert property (result_ready_o |=>
        !result_ready_o) else $error("ready longer than one cycle");
    a_result_stable: assert property ($changed(result_o) |->
        $past(result_ready_o)) else $error("result changed unannounced");
    c_ready: cover property (result_ready_o);
    c_ref_wr: cover property (ref_wr);
    c_conv: cover property ($rose(core_o.converting));
endmodule : acc_top_props

bind acc_top acc_top_props acc_top_props_inst (.*);

/* File: verification/acc_top_bench.sv */
// self-checking bench for the conversion configuration block
`timescale 1ns/100ps
module acc_top_bench;
    import acc_pkg::*;
    logic clk_i = 0, rst_i = 1, wb_we_i = 0, wb_stb_i = 0, wb_cyc_i = 0;
    logic trigger_i = 0, ref_buffer_comp_en_o, wb_ack_o, result_ready_o;
    logic [7:0] wb_adr_i = 0;
    logic [31:0] wb_dat_i = 0, wb_dat_o, q, v, seed = 32'h065FF24B;
    logic [3:0] wb_sel_i = 0, ref_select_o;
    logic [11:0] core_result_i = 0;
    logic [15:0] result_o;
    logic [15:0] cases [7] = '{16'h0000, 16'h2400, 16'h2080, 16'h0100,
        16'h0180, 16'h10C5, 16'h0020};
    acc_core_t core_o;
    int n_errors = 0, tests_run = 0, n;
    // 40 MHz clock
    always #12.5 clk_i = ~clk_i;
    acc_top acc_top_inst (.*);
    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    // expected result: trim, sum, shift, correct, clamp
    function automatic logic [31:0] exp_res(logic [11:0] r, logic [15:0] c);
        logic [31:0] x;
        logic [31:0] m;
        x = c[8:7] == 2'h2 ? r >> 2 : c[8:7] == 2'h3 ? r >> 4 : r;
        x = (x << c[15:12]) >> c[11:9];
        if (x > 32'hFFFF) x = 32'hFFFF;
        if (c[6]) x = x > c[3:0] ? x - c[3:0] : 32'h0;
        m = c[8:7] == 2'h0 ? 32'hFFF : c[8:7] == 2'h1 ? 32'hFFFF :
            c[8:7] == 2'h2 ? 32'h3FF : 32'hFF;
        return x > m ? m : x;
    endfunction : exp_res
    // one classic bus cycle, data left in q
    task automatic wb(logic [7:0] a, logic w, logic [31:0] d);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= 4'hF;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask : wb
    task automatic chk(logic [31:0] g, logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            n_errors++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : wrap_up
    // poll status until the pending copy has landed
    task automatic sync_wait();
        repeat (200) begin
            wb(8'h18, 1'b0, 32'h0);
            if (q[7] === 1'b0) return;
        end
        chk(q, 32'h0);
    endtask : sync_wait
    // configure, trigger and check one conversion run
    task automatic run_conv(logic [15:0] c);
        logic [5:0] len;
        logic [2:0] p;
        logic [31:0] e;
        len = 6'(rnd() % 8);
        p = 3'(rnd() % 3);
        core_result_i <= 12'(rnd());
        wb(8'h08, 1'b1, {25'h0, c[11:9], c[15:12]});
        wb(8'h0C, 1'b1, {26'h0, len});
        wb(8'h28, 1'b1, {28'h0, c[3:0]});
        wb(8'h10, 1'b1, {21'h0, p, 2'h0, c[8:7], c[6], c[5], 2'h0});
        sync_wait();
        wb(8'h00, 1'b1, 32'h2);
        trigger_i <= 1'b1;
        @(posedge clk_i);
        trigger_i <= 1'b0;
        e = exp_res(core_result_i, c);
        while (core_o.sampling !== 1'b1) @(posedge clk_i);
        for (n = 0; core_o.sampling === 1'b1; n++) @(posedge clk_i);
        chk(n, (len + 1) * (2 << p));
        for (int k = 0; k <= int'(c[5]); k++) begin
            do @(posedge clk_i); while (result_ready_o !== 1'b1);
            @(posedge clk_i);
            chk(result_o, e);
        end
        wb(8'h00, 1'b1, 32'h0);
        $display("conversion %h done", c);
    endtask : run_conv
    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        for (int i = 1; i < 5; i++) begin
            wb(8'(i * 4), 1'b0, 32'h0);
            chk(q, 32'h0);
        end
        wb(8'h24, 1'b0, 32'h0);
        chk(q, 32'h800);
        $display("reset values done");
        for (int i = 0; i < 16; i++) begin
            v = {rnd()} & 32'hF0 | i;
            wb(8'h04, 1'b1, v);
            wb(8'h04, 1'b0, 32'h0);
            chk(q, v & 32'h8F);
            chk({ref_buffer_comp_en_o, 3'h0, ref_select_o}, v & 32'h8F);
        end
        v = rnd();
        wb(8'h08, 1'b1, v);
        wb(8'h08, 1'b0, 32'h0);
        chk(q, v & 32'h7F);
        v = rnd();
        wb(8'h0C, 1'b1, v);
        wb(8'h0C, 1'b0, 32'h0);
        chk(q, v & 32'h3F);
        v = rnd();
        wb(8'h10, 1'b1, v);
        wb(8'h10, 1'b0, 32'h0);
        chk(q, v & 32'h73C);
        sync_wait();
        wb(8'h1C, 1'b1, rnd());
        wb(8'h1C, 1'b0, 32'h0);
        chk(q, 32'h0);
        $display("register access done");
        wb(8'h10, 1'b1, 32'h0);
        sync_wait();
        wb(8'h00, 1'b1, 32'h2);
        wb(8'h10, 1'b1, 32'h73C);
        wb(8'h10, 1'b0, 32'h0);
        chk(q, 32'h0);
        wb(8'h18, 1'b0, 32'h0);
        chk(q & 32'h80, 32'h0);
        wb(8'h00, 1'b1, 32'h0);
        $display("protection done");
        foreach (cases[i]) run_conv(cases[i]);
        wrap_up();
    end
    // watchdog well beyond the few thousand cycles the tests need
    initial begin
        repeat (100000) @(posedge clk_i);
        n_errors++;
        wrap_up();
    end
endmodule : acc_top_bench
